// ---- pkg/ditc_irq_if.sv ----
// Connection between the register front end and the two interrupt units.
`timescale 1ns/10ps
`default_nettype none
interface ditc_irq_if;
    logic [15:0] core_src;
    logic [15:0] core_mask;
    logic [15:0] core_pend;
    logic        core_ack;
    logic [3:0]  core_ack_chan;
    logic        core_irq;
    logic [3:0]  core_vec_chan;
    logic        core_vec_valid;
    logic [15:0] host_src;
    logic [15:0] host_mask;
    logic [15:0] host_status;
    logic        host_irq;

    modport ctrl (
        output core_src, core_mask, core_ack, core_ack_chan, host_src, host_mask,
        input  core_pend, core_irq, core_vec_chan, core_vec_valid, host_status, host_irq
    );
    modport core_unit (
        input  core_src, core_mask, core_ack, core_ack_chan,
        output core_pend, core_irq, core_vec_chan, core_vec_valid
    );
    modport host_unit (
        input  host_src, host_mask,
        output host_status, host_irq
    );
endinterface
`default_nettype wire

// ---- pkg/ditc_pkg.sv ----
// Shared constants for the dual interrupt and trigger controller.
package ditc_pkg;

    // ------------------------------------------------------------
    // Bus and channel geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned NCH       = 16;
    localparam int unsigned NTRIG     = 5;
    localparam int unsigned FIRST_IRQ = 5;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_HOST_MASK      = 12'h018;
    localparam logic [11:0] OFS_HOST_STATUS    = 12'h01c;
    localparam logic [11:0] OFS_CORE_MASK      = 12'h064;
    localparam logic [11:0] OFS_CORE_STATUS    = 12'h068;
    localparam logic [11:0] OFS_CORE_VECTOR    = 12'h06c;
    localparam logic [11:0] OFS_TRIG_MODE      = 12'h070;
    localparam logic [11:0] OFS_SW_TRIG        = 12'h074;
    localparam logic [11:0] OFS_HOST_TO_CORE   = 12'h078;
    localparam logic [11:0] OFS_CORE_TO_HOST   = 12'h07c;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] RST_MASK        = 16'h0000;
    localparam logic [4:0]  RST_TRIG_MODE   = 5'h00;
    localparam logic [23:0] RST_VEC_BASE    = 24'h000000;
    localparam logic [3:0]  RST_CORE_TO_HOST = 4'h0;
    localparam int unsigned VEC_VALID_BIT   = 4;
    localparam int unsigned VEC_BASE_LSB    = 8;

    // Internal unit channel numbers.
    localparam logic [3:0] CCH_DMA_TC     = 4'h5;
    localparam logic [3:0] CCH_EXT_BUS    = 4'h6;
    localparam logic [3:0] CCH_ENC_FULL   = 4'h7;
    localparam logic [3:0] CCH_DEC_TREF   = 4'h8;
    localparam logic [3:0] CCH_ENC_TREF   = 4'h9;
    localparam logic [3:0] CCH_TIMER0     = 4'ha;
    localparam logic [3:0] CCH_TIMER1     = 4'hb;
    localparam logic [3:0] CCH_HOST_CMD   = 4'hc;
    localparam logic [3:0] CCH_DEC_DONE   = 4'hd;
    localparam logic [3:0] CCH_ALIGN_LOSS = 4'he;
    localparam logic [3:0] CCH_RUN_LEVEL  = 4'hf;

    // Host-side unit channel positions.
    localparam int unsigned HCH_DMA_LSB  = 0;
    localparam int unsigned HCH_CORE_LSB = 8;
    localparam int unsigned HCH_EXT_BUS  = 12;
    localparam int unsigned HCH_DMA_TC   = 13;
    localparam int unsigned HCH_FRM_TC   = 14;
    localparam int unsigned HCH_CORE_IRQ = 15;

endpackage

// ---- rtl/ditc_core_irq_unit.sv ----
// Internal interrupt unit: pending latches, masking and vector priority.
`timescale 1ns/10ps
`default_nettype none
module ditc_core_irq_unit
    import ditc_pkg::*;
(
    input  wire logic      i_sys_clk,
    input  wire logic      i_srst,
    ditc_irq_if.core_unit  irq
);

    logic [15:0] clr;
    logic [15:0] active;

    // ------------------------------------------------------------
    // Pending latches
    // ------------------------------------------------------------
    // R15 latch until acknowledge
    // A source active in the clearing cycle stays pending: set wins.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            irq.core_pend <= 16'h0000;
        end else begin
            irq.core_pend <= ((irq.core_pend & ~clr) | irq.core_src) & 16'hffe0;
        end
    end

    // R7 acknowledge clears channel
    always_comb begin
        clr = 16'h0000;
        if (irq.core_ack) begin
            clr[irq.core_ack_chan] = 1'b1;
        end
    end

    // R5 mask gates request
    assign active   = irq.core_pend & irq.core_mask;
    // R6 request from enabled pending
    assign irq.core_irq = |active;

    // Lowest channel number is served first.
    always_comb begin
        irq.core_vec_chan  = 4'h0;
        irq.core_vec_valid = 1'b0;
        for (int i = NCH - 1; i >= int'(FIRST_IRQ); i--) begin
            if (active[i]) begin
                irq.core_vec_chan  = 4'(i);
                irq.core_vec_valid = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pend_latch_set: assert property ( // R15
        @(posedge i_sys_clk) disable iff (i_srst)
        (irq.core_src[CCH_TIMER0]) |=> irq.core_pend[CCH_TIMER0])
        else $error("Active source did not become pending.");

    a_ack_clears_pend: assert property ( // R7
        @(posedge i_sys_clk) disable iff (i_srst)
        (irq.core_ack && !irq.core_src[irq.core_ack_chan])
            |=> !irq.core_pend[$past(irq.core_ack_chan)])
        else $error("Acknowledged channel stayed pending.");

    a_mask_blocks_irq: assert property ( // R5
        @(posedge i_sys_clk) disable iff (i_srst)
        ((irq.core_pend & irq.core_mask) == 16'h0000) |-> !irq.core_irq && !irq.core_vec_valid)
        else $error("Masked channel raised the request.");

endmodule
`default_nettype wire

// ---- rtl/ditc_host_irq_unit.sv ----
// Host-side interrupt unit: sixteen channels merged into one host request.
`timescale 1ns/10ps
`default_nettype none
module ditc_host_irq_unit
    import ditc_pkg::*;
(
    input  wire logic      i_sys_clk,
    input  wire logic      i_srst,
    ditc_irq_if.host_unit  irq
);

    // ------------------------------------------------------------
    // Status and merge
    // ------------------------------------------------------------
    // R8 sample all sixteen channels
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            irq.host_status <= 16'h0000;
        end else begin
            irq.host_status <= irq.host_src;
        end
    end

    // R12 masked channels never request
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            irq.host_irq <= 1'b0;
        end else begin
            irq.host_irq <= |(irq.host_src & irq.host_mask);
        end
    end

    a_host_status_track: assert property ( // R8
        @(posedge i_sys_clk) disable iff (i_srst)
        ##1 (irq.host_status == $past(irq.host_src)))
        else $error("Host status does not follow its sources.");

    a_host_irq_mask: assert property ( // R12
        @(posedge i_sys_clk) disable iff (i_srst)
        ((irq.host_src & irq.host_mask) == 16'h0000) |=> !irq.host_irq)
        else $error("Masked host channel raised the request.");

endmodule
`default_nettype wire

// ---- rtl/ditc_top.sv ----
// Register front end and trigger logic joining the internal and host-side units.
//
// Operation
// R1: The internal unit delivers interrupt channels to the embedded core and five engine trigger outputs.
// R2: Triggers 0 to 4 start capture, motion search, loop filter, inverse transform and forward transform.
// R3: Channels 5 to 9 carry DMA terminal count, external bus, encoder FIFO full and the two temporal-reference events.
// R4: Channels 10 to 15 carry both timer timeouts, host command, decode done, alignment loss and run-level error.
// R5: Each internal channel has its own mask bit, and a masked channel raises no request.
// R6: An enabled active channel shows in the status register and raises the core request line.
// R7: A read of the vector register pulses the acknowledge and clears the served channel.
// R8: The host-side unit merges sixteen channels into the host interrupt line.
// R9: Host channels 0 to 7 follow the external-memory DMA request lines.
// R10: Host channels 8 to 11 are raised by the embedded core.
// R11: Host channels 12 to 15 carry external bus, both DMA terminal counts and the internal unit output.
// R12: Every host channel has a mask bit, and a masked channel never drives the host line.
// R13: Host software reads the host status register to find the raising channel.
// R14: A write to the host command register gives one pulse on internal channel 12.
// R15: An internal channel stays pending from activation until its acknowledge.
// R16: The host line is driven low while any unmasked host channel is active, and released otherwise.
// R17: A software trigger write pulses for one cycle each trigger written as one in software mode.
`timescale 1ns/10ps
`default_nettype none
module ditc_top
    import ditc_pkg::*;
(
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_srst,
    input  wire logic                       i_reg_wr,
    input  wire logic                       i_reg_rd,
    input  wire logic [ditc_pkg::ADDR_W-1:0] i_reg_addr,
    input  wire logic [ditc_pkg::DATA_W-1:0] i_reg_wdata,
    output logic      [ditc_pkg::DATA_W-1:0] o_reg_rdata,
    output logic                            o_reg_rvalid,
    input  wire logic [ditc_pkg::NTRIG-1:0] i_engine_ready,
    output logic      [ditc_pkg::NTRIG-1:0] o_trigger,
    input  wire logic                       i_external_memory_dma_tc,
    input  wire logic                       i_ext_bus_irq,
    input  wire logic                       i_variable_length_encoder_full,
    input  wire logic                       i_dec_temporal_ref,
    input  wire logic                       i_enc_temporal_ref,
    input  wire logic                       i_timer0_timeout,
    input  wire logic                       i_timer1_timeout,
    input  wire logic                       i_decode_done,
    input  wire logic                       i_align_loss,
    input  wire logic                       i_run_level_err,
    input  wire logic [7:0]                 i_external_memory_dma_req,
    input  wire logic                       i_frame_memory_dma_tc,
    output logic                            o_core_irq,
    output logic                            o_core_irq_acknowledge,
    output logic                            o_pci_core_irq_acknowledge_n_o,
    output logic                            o_pci_core_irq_acknowledge_n_oe
);

    ditc_irq_if irq ();

    logic [15:0] core_mask;
    logic [15:0] host_mask;
    logic [4:0]  trigger_mode;
    logic [23:0] vec_base;
    logic [3:0]  core_to_host;
    logic        host_cmd_pulse;
    logic [4:0]  ready_prev;
    logic        sw_trig_wr;
    logic        vec_rd;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Interrupt units
    // ------------------------------------------------------------
    ditc_core_irq_unit u_core (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .irq       (irq.core_unit)
    );

    ditc_host_irq_unit u_host (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .irq       (irq.host_unit)
    );

    // ------------------------------------------------------------
    // Source wiring
    // ------------------------------------------------------------
    // R1 eleven interrupt channels toward the core
    always_comb begin
        irq.core_src = 16'h0000;
        // R3 DMA, bus, encoder and reference events
        irq.core_src[CCH_DMA_TC]     = i_external_memory_dma_tc;
        irq.core_src[CCH_EXT_BUS]    = i_ext_bus_irq;
        irq.core_src[CCH_ENC_FULL]   = i_variable_length_encoder_full;
        irq.core_src[CCH_DEC_TREF]   = i_dec_temporal_ref;
        irq.core_src[CCH_ENC_TREF]   = i_enc_temporal_ref;
        // R4 timers, host, decoder events
        irq.core_src[CCH_TIMER0]     = i_timer0_timeout;
        irq.core_src[CCH_TIMER1]     = i_timer1_timeout;
        irq.core_src[CCH_HOST_CMD]   = host_cmd_pulse;
        irq.core_src[CCH_DEC_DONE]   = i_decode_done;
        irq.core_src[CCH_ALIGN_LOSS] = i_align_loss;
        irq.core_src[CCH_RUN_LEVEL]  = i_run_level_err;
    end

    always_comb begin
        irq.host_src = 16'h0000;
        // R9 DMA request lines
        irq.host_src[HCH_DMA_LSB +: 8]  = i_external_memory_dma_req;
        // R10 core-raised channels
        irq.host_src[HCH_CORE_LSB +: 4] = core_to_host;
        // R11 bus, terminal counts, internal unit
        irq.host_src[HCH_EXT_BUS]       = i_ext_bus_irq;
        irq.host_src[HCH_DMA_TC]        = i_external_memory_dma_tc;
        irq.host_src[HCH_FRM_TC]        = i_frame_memory_dma_tc;
        irq.host_src[HCH_CORE_IRQ]      = irq.core_irq;
    end

    assign irq.core_mask = core_mask;
    assign irq.host_mask = host_mask;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            core_mask    <= RST_MASK;
            host_mask    <= RST_MASK;
            trigger_mode <= RST_TRIG_MODE;
            vec_base     <= RST_VEC_BASE;
            core_to_host <= RST_CORE_TO_HOST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == OFS_CORE_MASK) begin
                // R5 per-channel enables
                core_mask <= i_reg_wdata[15:0] & 16'hffe0;
            end else if (i_reg_addr == OFS_HOST_MASK) begin
                // R12 per-channel enables
                host_mask <= i_reg_wdata[15:0];
            end else if (i_reg_addr == OFS_TRIG_MODE) begin
                trigger_mode <= i_reg_wdata[4:0];
            end else if (i_reg_addr == OFS_CORE_VECTOR) begin
                vec_base <= i_reg_wdata[31:8];
            end else if (i_reg_addr == OFS_CORE_TO_HOST) begin
                // R10 core raises host channels
                core_to_host <= i_reg_wdata[3:0];
            end
        end
    end

    // R14 single pulse per command write
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            host_cmd_pulse <= 1'b0;
        end else begin
            host_cmd_pulse <= i_reg_wr && (i_reg_addr == OFS_HOST_TO_CORE);
        end
    end

    // ------------------------------------------------------------
    // Triggers
    // ------------------------------------------------------------
    // Mode bit zero selects the software register, one the engine ready edge.
    assign sw_trig_wr = i_reg_wr && (i_reg_addr == OFS_SW_TRIG);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ready_prev <= 5'h00;
        end else begin
            ready_prev <= i_engine_ready;
        end
    end

    // R2 one start output per engine
    for (genvar t = 0; t < NTRIG; t++) begin : g_trig
        // R17 one-cycle start pulse
        always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
                o_trigger[t] <= 1'b0;
            end else if (trigger_mode[t]) begin
                o_trigger[t] <= i_engine_ready[t] && !ready_prev[t];
            end else begin
                o_trigger[t] <= sw_trig_wr && i_reg_wdata[t];
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads and acknowledge
    // ------------------------------------------------------------
    assign vec_rd = i_reg_rd && (i_reg_addr == OFS_CORE_VECTOR);

    // R7 vector read acknowledges the served channel
    assign irq.core_ack      = vec_rd && irq.core_vec_valid;
    assign irq.core_ack_chan = irq.core_vec_chan;

    always_comb begin
        next_rdata = 32'h00000000;
        if (i_reg_addr == OFS_CORE_MASK) begin
            next_rdata[15:0] = core_mask;
        end else if (i_reg_addr == OFS_CORE_STATUS) begin
            // R6 enabled active channels
            next_rdata[15:0] = irq.core_pend & core_mask;
        end else if (i_reg_addr == OFS_CORE_VECTOR) begin
            next_rdata[3:0]                   = irq.core_vec_chan;
            next_rdata[VEC_VALID_BIT]         = irq.core_vec_valid;
            next_rdata[31:VEC_BASE_LSB]       = vec_base;
        end else if (i_reg_addr == OFS_TRIG_MODE) begin
            next_rdata[4:0] = trigger_mode;
        end else if (i_reg_addr == OFS_HOST_MASK) begin
            next_rdata[15:0] = host_mask;
        end else if (i_reg_addr == OFS_HOST_STATUS) begin
            // R13 host finds the raising channel here
            next_rdata[15:0] = irq.host_status;
        end else if (i_reg_addr == OFS_CORE_TO_HOST) begin
            next_rdata[3:0] = core_to_host;
        end
    end

    // Read data is held until the next read so software may sample late.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_reg_rdata <= 32'h00000000;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_reg_rvalid           <= 1'b0;
            o_core_irq_acknowledge <= 1'b0;
        end else begin
            o_reg_rvalid           <= i_reg_rd;
            o_core_irq_acknowledge <= irq.core_ack;
        end
    end

    // ------------------------------------------------------------
    // Request outputs
    // ------------------------------------------------------------
    // R6 core request line
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_core_irq <= 1'b0;
        end else begin
            o_core_irq <= irq.core_irq;
        end
    end

    // R16 open-drain host line, low while any unmasked channel is active
    assign o_pci_core_irq_acknowledge_n_o  = 1'b0;
    assign o_pci_core_irq_acknowledge_n_oe = irq.host_irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sw_trig_pulse: assert property ( // R17
        @(posedge i_sys_clk) disable iff (i_srst)
        (sw_trig_wr && i_reg_wdata[0] && !trigger_mode[0]) |=> o_trigger[0] ##1 !o_trigger[0])
        else $error("Software trigger did not give a single pulse.");

    a_trig_mode_block: assert property ( // R17
        @(posedge i_sys_clk) disable iff (i_srst)
        (trigger_mode[1] && !i_engine_ready[1]) |=> !o_trigger[1])
        else $error("Hardware-mode trigger fired without an engine edge.");

    a_host_cmd_pulse: assert property ( // R14
        @(posedge i_sys_clk) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == OFS_HOST_TO_CORE && core_mask[CCH_HOST_CMD])
            |=> irq.core_src[CCH_HOST_CMD] ##1 irq.core_pend[CCH_HOST_CMD] ##1 o_core_irq)
        else $error("Host command did not reach the core request.");

    a_vector_ack: assert property ( // R7
        @(posedge i_sys_clk) disable iff (i_srst)
        (vec_rd && irq.core_vec_valid) |=> o_core_irq_acknowledge && o_reg_rvalid
            && (o_reg_rdata[3:0] == $past(irq.core_vec_chan)))
        else $error("Vector read did not acknowledge its channel.");

    a_no_ack_idle: assert property ( // R7
        @(posedge i_sys_clk) disable iff (i_srst)
        !vec_rd |=> !o_core_irq_acknowledge)
        else $error("Acknowledge without a vector read.");

    a_core_irq_acknowledge_drive: assert property ( // R16
        @(posedge i_sys_clk) disable iff (i_srst)
        ((irq.host_src & host_mask) != 16'h0000) |=> o_pci_core_irq_acknowledge_n_oe && !o_pci_core_irq_acknowledge_n_o)
        else $error("Host line not driven for an unmasked channel.");

    a_core_to_host: assert property ( // R11
        @(posedge i_sys_clk) disable iff (i_srst)
        (irq.core_irq && host_mask[HCH_CORE_IRQ]) |=> o_pci_core_irq_acknowledge_n_oe)
        else $error("Internal unit request did not reach the host line.");

endmodule
`default_nettype wire

// ---- verif/ditc_far_model.sv ----
// Far-side model: pulled-up host line and a count of core acknowledges.
`timescale 1ns/10ps
`default_nettype none
module ditc_far_model (
    input  wire logic i_sys_clk,
    input  wire logic i_ack,
    input  wire logic i_core_irq_acknowledge_o,
    input  wire logic i_core_irq_acknowledge_oe,
    output logic      o_core_irq_acknowledge_level,
    output var int    o_acks
);
    // host line pull-up
    // Released line reads high through the board pull-up, never the last driven value.
    assign o_core_irq_acknowledge_level = i_core_irq_acknowledge_oe ? i_core_irq_acknowledge_o : 1'b1;
    initial o_acks = 0;
    always @(posedge i_sys_clk) begin
        if (i_ack === 1'b1) begin
            o_acks <= o_acks + 1;
        end
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the dual interrupt and trigger controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ditc_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        rvalid;
    logic [4:0]  rdy = 5'h00;
    logic [4:0]  trig;
    logic [15:0] src = 16'h0000;
    logic [7:0]  xreq = 8'h00;
    logic        fmem_tc = 1'b0;
    logic        irq, ack, core_irq_acknowledge_o, core_irq_acknowledge_oe, core_irq_acknowledge, a;
    int          acks;
    int          n_errors = 0;
    int          samples_checked = 0;

    always #12.5 clk = ~clk;

    ditc_top uut (
        .i_sys_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_engine_ready(rdy),
        .o_trigger(trig), .i_external_memory_dma_tc(src[5]), .i_ext_bus_irq(src[6]),
        .i_variable_length_encoder_full(src[7]), .i_dec_temporal_ref(src[8]), .i_enc_temporal_ref(src[9]),
        .i_timer0_timeout(src[10]), .i_timer1_timeout(src[11]), .i_decode_done(src[13]),
        .i_align_loss(src[14]), .i_run_level_err(src[15]), .i_external_memory_dma_req(xreq),
        .i_frame_memory_dma_tc(fmem_tc), .o_core_irq(irq), .o_core_irq_acknowledge(ack),
        .o_pci_core_irq_acknowledge_n_o(core_irq_acknowledge_o), .o_pci_core_irq_acknowledge_n_oe(core_irq_acknowledge_oe)
    );
    ditc_far_model far (
        .i_sys_clk(clk), .i_ack(ack), .i_core_irq_acknowledge_o(core_irq_acknowledge_o), .i_core_irq_acknowledge_oe(core_irq_acknowledge_oe),
        .o_core_irq_acknowledge_level(core_irq_acknowledge), .o_acks(acks)
    );

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [11:0] ad, input logic [31:0] dt);
        wr    = 1'b1;
        addr  = ad;
        wdata = dt;
        // Strobe drops at the taking edge so a following call may raise it again.
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // The answer is registered, so it is taken one edge after the strobe.
    task automatic rreg(input logic [11:0] ad, input logic [31:0] exp);
        rd   = 1'b1;
        addr = ad;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        chk("rdata", rdata, exp);
        a = ack;
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        tick(8);
        srst = 1'b0;
        rreg(OFS_CORE_MASK, 32'h0);
        rreg(OFS_HOST_MASK, 32'h0);
        rreg(OFS_TRIG_MODE, 32'h0);
        rreg(12'h100, 32'h0);
        wreg(OFS_CORE_MASK, 32'hffffffff);
        rreg(OFS_CORE_MASK, 32'h0000ffe0);
        $display("test reset done");
        for (int ch = 5; ch < 16; ch++) begin
            if (ch == 12) begin
                wreg(OFS_HOST_TO_CORE, 32'h0);
            end else begin
                src[ch] = 1'b1;
                tick(1);
                src[ch] = 1'b0;
            end
            tick(3);
            chk("core_irq", {31'h0, irq}, 32'h1);
            rreg(OFS_CORE_STATUS, 32'h1 << ch);
            rreg(OFS_CORE_VECTOR, 32'h10 | ch);
            chk("ack", {31'h0, a}, 32'h1);
            tick(1);
            chk("core_irq_low", {31'h0, irq}, 32'h0);
        end
        wreg(OFS_CORE_MASK, 32'h0);
        src[10] = 1'b1;
        tick(1);
        src[10] = 1'b0;
        tick(3);
        chk("masked_irq", {31'h0, irq}, 32'h0);
        rreg(OFS_CORE_STATUS, 32'h0);
        wreg(OFS_CORE_MASK, 32'h400);
        tick(2);
        chk("late_irq", {31'h0, irq}, 32'h1);
        rreg(OFS_CORE_VECTOR, 32'h1a);
        rreg(OFS_CORE_VECTOR, 32'h0);
        chk("no_ack", {31'h0, a}, 32'h0);
        $display("test core done");
        wreg(OFS_SW_TRIG, 32'h1f);
        chk("trig", {27'h0, trig}, 32'h1f);
        tick(1);
        chk("trig_end", {27'h0, trig}, 32'h0);
        wreg(OFS_TRIG_MODE, 32'h2);
        rreg(OFS_TRIG_MODE, 32'h2);
        rdy[1] = 1'b1;
        tick(1);
        chk("trig_hw", {27'h0, trig}, 32'h2);
        tick(1);
        chk("trig_hw_end", {27'h0, trig}, 32'h0);
        wreg(OFS_SW_TRIG, 32'h3);
        chk("trig_sw", {27'h0, trig}, 32'h1);
        $display("test trigger done");
        wreg(OFS_CORE_MASK, 32'h0);
        wreg(OFS_HOST_MASK, 32'hffff);
        for (int i = 0; i < 16; i++) begin
            case (i)
                8, 9, 10, 11: wreg(OFS_CORE_TO_HOST, 32'h1 << (i - 8));
                12: src[6] = 1'b1;
                13: src[5] = 1'b1;
                14: fmem_tc = 1'b1;
                15: wreg(OFS_CORE_MASK, 32'h60);
                default: xreq[i] = 1'b1;
            endcase
            tick(4);
            chk("core_irq_acknowledge", {31'h0, core_irq_acknowledge}, 32'h0);
            rreg(OFS_HOST_STATUS, 32'h1 << i);
            xreq = 8'h00;
            src  = 16'h0000;
            fmem_tc = 1'b0;
            wreg(OFS_CORE_TO_HOST, 32'h0);
            wreg(OFS_CORE_MASK, 32'h0);
            tick(3);
            chk("core_irq_acknowledge_off", {31'h0, core_irq_acknowledge}, 32'h1);
        end
        wreg(OFS_HOST_MASK, 32'hfffe);
        xreq[0] = 1'b1;
        tick(3);
        chk("core_irq_acknowledge_masked", {31'h0, core_irq_acknowledge}, 32'h1);
        rreg(OFS_HOST_STATUS, 32'h1);
        chk("acks", acks, 32'd12);
        $display("test host done");
        print_verdict();
    end

    // Generous bound: the tests need well under a thousand cycles.
    initial begin
        tick(5000);
        n_errors++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
`default_nettype wire
